// File: hw/ldd_pkg.sv
/*
  Shared constants for the sixteen-channel LED blink driver:
  register map, field positions, reset values and blink timing.
  Assumes a 20 MHz system clock.
*/
package ldd_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int BLINK_BASE_HZ = 160;
  localparam int DUTY_STEPS = 256;
  localparam int STEP_HZ = BLINK_BASE_HZ * DUTY_STEPS;
  // rounds down: the blink runs about 0.06 percent fast
  localparam int STEP_CYC = CLK_HZ / STEP_HZ;
  localparam int RATE_W = 8;
  localparam int LED_N = 16;
  localparam int CFG_N = 8;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] REG_PINS_LO = 4'h0;
  localparam logic [3:0] REG_PINS_HI = 4'h1;
  localparam logic [3:0] REG_PSC_A = 4'h2;
  localparam logic [3:0] REG_DUTY_A = 4'h3;
  localparam logic [3:0] REG_PSC_B = 4'h4;
  localparam logic [3:0] REG_DUTY_B = 4'h5;
  localparam logic [3:0] REG_SEL_A = 4'h6;
  localparam logic [3:0] REG_SEL_D = 4'h9;
  localparam logic [3:0] REG_FIRST_RW = REG_PSC_A;
  localparam logic [3:0] REG_LAST = REG_SEL_D;
  localparam int CFG_SEL0 = 4;
  localparam int AI_BIT = 4;
  localparam logic [3:0] DEV_ADDR_HI = 4'hc;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_RATE_A = 2'h2;
  localparam logic [1:0] MODE_RATE_B = 2'h3;
  localparam logic [7:0] PSC_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h80;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0][7:0] CFG_RST = {SEL_RST, SEL_RST, SEL_RST,
    SEL_RST, DUTY_RST, PSC_RST, DUTY_RST, PSC_RST};
endpackage

// File: hw/ldd_sync.sv
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a level that may be sampled bit by bit.
*/
`timescale 1ns/1ps
`default_nettype none
module ldd_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  if (W < 1) begin : g_bad
    $error("ldd_sync width must be at least one");
  end

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } ldd_sync_t;

  ldd_sync_t q, d;

  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign dout = q.s2;
endmodule
`default_nettype wire

// File: hw/ldd_blink.sv
/*
  One blink rate: prescaled step counter and 8-bit duty compare.
  Assumes step is a one-cycle pulse at 256 times the base rate.
*/
`timescale 1ns/1ps
`default_nettype none
module ldd_blink import ldd_pkg::*; #(
  parameter int W = RATE_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control
  input wire logic step,
  input wire logic restart,
  input wire logic [W-1:0] prescale,
  input wire logic [W-1:0] duty,
  // result
  output logic on
);
  if (W != RATE_W) begin : g_bad
    $error("ldd_blink supports only the 8-bit rate registers");
  end

  typedef struct packed {
    logic [W-1:0] sub;
    logic [W-1:0] phase;
    logic on;
  } ldd_blink_t;

  ldd_blink_t q, d;

  always_comb begin
    d = q;
    if (restart) begin
      d.sub = '0;
      d.phase = '0;
    end else if (step) begin
      if (q.sub == prescale) begin
        d.sub = '0;
        d.phase = q.phase + 1'b1;
      end else begin
        d.sub = q.sub + 1'b1;
      end
    end
    d.on = q.phase < duty;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign on = q.on;

  chk_duty_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    duty == '0 |=> !q.on)
    else $error("output on with zero duty");

  chk_restart_clear: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    restart |=> q.sub == '0 && q.phase == '0)
    else $error("counter not restarted");

  chk_phase_step: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    step && !restart && q.sub == prescale
    |=> q.phase == $past(q.phase) + 1'b1 && q.sub == '0)
    else $error("phase did not advance after prescale steps");
endmodule
`default_nettype wire

// File: hw/ldd_top.sv
/*
  Sixteen-channel LED blink driver with a two-wire serial slave.
  The serial slave and register file run on link_clk, which samples
  the bus pins; blink timing and LED outputs run on sys_clk.
  Assumes reset_n is synchronous to sys_clk and held low at power-up.
*/
`timescale 1ns/1ps
`default_nettype none
module ldd_top import ldd_pkg::*; #(
  parameter int STEP_CYCLES = STEP_CYC
) (
  // clocks and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // address select pins
  input wire logic address_select_0,
  input wire logic address_select_1,
  input wire logic address_select_2,
  // LED pins
  input wire logic [LED_N-1:0] led_output_n_i,
  output logic [LED_N-1:0] led_output_n_o,
  output logic [LED_N-1:0] led_output_n_oe
);
  if (STEP_CYCLES < 2 || STEP_CYCLES > 511) begin : g_bad
    $error("ldd_top STEP_CYCLES must lie in 2 to 511");
  end

  // ****************************************
  // link domain: pin sampling
  // ****************************************
  typedef enum logic [2:0] {
    LK_IDLE, LK_DEV, LK_REG, LK_WR, LK_RD
  } ldd_lstate_t;

  typedef struct packed {
    ldd_lstate_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic ai;
    logic nack;
    logic [3:0] ptr;
    logic [CFG_N-1:0][7:0] cfg;
    logic upd;
    logic [2:0] wsel;
    logic sda_oe;
    logic sda_o;
    logic scl_p;
    logic sda_p;
  } ldd_link_t;

  ldd_link_t l, ln;
  logic lrst_n;
  logic [LED_N+4:0] pins_s;
  logic [LED_N-1:0] led_s;
  logic [2:0] adr_s;
  logic scl_s, sda_s;

  ldd_sync #(.W(1)) u_lrst (
    .clk(link_clk),
    .din(reset_n),
    .dout(lrst_n)
  );

  ldd_sync #(.W(LED_N + 5)) u_lpins (
    .clk(link_clk),
    .din({led_output_n_i, address_select_2, address_select_1,
      address_select_0, scl_i, sda_i}),
    .dout(pins_s)
  );

  assign led_s = pins_s[LED_N+4:5];
  assign adr_s = pins_s[4:2];
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // ****************************************
  // link domain: bus events and register access
  // ****************************************
  logic start, stop, scl_rise, scl_fall, byte_end;
  logic wr_ok;
  logic [2:0] widx;
  logic [3:0] wr_next, rd_next;
  logic [7:0] rdat;

  assign start = scl_s && l.scl_p && l.sda_p && !sda_s;
  assign stop = scl_s && l.scl_p && !l.sda_p && sda_s;
  assign scl_rise = scl_s && !l.scl_p;
  assign scl_fall = !scl_s && l.scl_p;
  assign byte_end = scl_fall && l.cnt == 4'h8 && l.st != LK_IDLE;
  assign wr_ok = l.ptr >= REG_FIRST_RW && l.ptr <= REG_LAST;
  assign widx = 3'(l.ptr - REG_FIRST_RW);
  assign wr_next = (l.ptr >= REG_LAST) ? REG_FIRST_RW : l.ptr + 4'h1;
  assign rd_next = (l.ptr >= REG_LAST) ? REG_PINS_LO : l.ptr + 4'h1;

  always_comb begin
    rdat = 8'h00;
    if (l.ptr == REG_PINS_LO) begin
      rdat = led_s[7:0];
    end else if (l.ptr == REG_PINS_HI) begin
      rdat = led_s[15:8];
    end else if (wr_ok) begin
      rdat = l.cfg[widx];
    end
  end

  always_comb begin
    ln = l;
    ln.scl_p = scl_s;
    ln.sda_p = sda_s;
    if (start) begin
      ln.st = LK_DEV;
      ln.cnt = 4'h0;
      ln.sda_oe = 1'b0;
      ln.nack = 1'b0;
    end else if (stop) begin
      ln.st = LK_IDLE;
      ln.sda_oe = 1'b0;
    end else if (l.st != LK_IDLE && scl_rise) begin
      if (l.cnt < 4'h8) begin
        ln.cnt = l.cnt + 4'h1;
        if (l.st != LK_RD) begin
          ln.sh = {l.sh[6:0], sda_s};
        end
      end else begin
        ln.cnt = 4'h9;
        if (l.st == LK_RD) begin
          ln.nack = sda_s;
        end
      end
    end else if (l.st != LK_IDLE && scl_fall) begin
      if (l.cnt == 4'h8) begin
        case (l.st)
          LK_DEV: begin
            if (l.sh[7:1] == {DEV_ADDR_HI, adr_s}) begin
              ln.rw = l.sh[0];
              ln.sda_oe = 1'b1;
            end else begin
              ln.st = LK_IDLE;
            end
          end
          LK_REG: begin
            ln.ai = l.sh[AI_BIT];
            ln.ptr = l.sh[3:0];
            ln.sda_oe = 1'b1;
          end
          LK_WR: begin
            ln.sda_oe = 1'b1;
            if (wr_ok) begin
              ln.cfg[widx] = l.sh;
              ln.upd = ~l.upd;
              ln.wsel = widx;
            end
            if (l.ai) begin
              ln.ptr = wr_next;
            end
          end
          LK_RD: begin
            ln.sda_oe = 1'b0;
            if (l.ai) begin
              ln.ptr = rd_next;
            end
          end
          default: begin
            ln.st = LK_IDLE;
          end
        endcase
      end else if (l.cnt == 4'h9) begin
        ln.cnt = 4'h0;
        ln.sda_oe = 1'b0;
        case (l.st)
          LK_DEV: begin
            if (l.rw) begin
              ln.st = LK_RD;
              ln.sh = rdat;
              ln.sda_oe = ~rdat[7];
            end else begin
              ln.st = LK_REG;
            end
          end
          LK_REG: begin
            ln.st = LK_WR;
          end
          LK_RD: begin
            if (l.nack) begin
              ln.st = LK_IDLE;
            end else begin
              ln.sh = rdat;
              ln.sda_oe = ~rdat[7];
            end
          end
          default: begin
            ln.st = l.st;
          end
        endcase
      end else if (l.st == LK_RD && l.cnt != 4'h0) begin
        // only on falling clock, so the level holds while high
        ln.sh = {l.sh[6:0], 1'b0};
        ln.sda_oe = ~l.sh[6];
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      l <= '0;
      l.cfg <= CFG_RST;
      l.scl_p <= 1'b1;
      l.sda_p <= 1'b1;
    end else begin
      l <= ln;
    end
  end

  assign sda_o = l.sda_o;
  assign sda_oe = l.sda_oe;

  chk_addr_ack: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    byte_end && l.st == LK_DEV && l.sh[7:1] == {DEV_ADDR_HI, adr_s}
    |=> l.sda_oe && l.rw == $past(l.sh[0]))
    else $error("own address not acknowledged");

  chk_ro_ignore: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    byte_end && l.st == LK_WR && l.ptr < REG_FIRST_RW
    |=> $stable(l.cfg) && l.sda_oe)
    else $error("read-only write changed state or was refused");

  chk_wrap_write: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    byte_end && l.st == LK_WR && l.ai && l.ptr == REG_LAST
    |=> l.ptr == REG_FIRST_RW)
    else $error("write address did not wrap to 2");

  chk_wrap_read: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    byte_end && l.st == LK_RD && l.ai && l.ptr == REG_LAST
    |=> l.ptr == REG_PINS_LO)
    else $error("read address did not wrap to 0");

  chk_hold_address: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    byte_end && l.st == LK_WR && !l.ai
    |=> $stable(l.ptr) ##1 $stable(l.ptr))
    else $error("address moved without auto-increment");

  chk_drive_low: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    $rose(l.sda_oe) |-> !$past(scl_s))
    else $error("data line taken while clock high");

  chk_start_restart: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    start |=> l.st == LK_DEV && l.cnt == 4'h0 && !l.sda_oe)
    else $error("start did not restart the frame");

  chk_stop_idle: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    stop |=> l.st == LK_IDLE && !l.sda_oe)
    else $error("stop did not free the bus");

  cov_read_byte: cover property (
    @(posedge link_clk) disable iff (!lrst_n)
    byte_end && l.st == LK_RD);

  cov_write_ai: cover property (
    @(posedge link_clk) disable iff (!lrst_n)
    byte_end && l.st == LK_WR && l.ai && l.ptr == REG_LAST);

  // ****************************************
  // system domain: configuration capture
  // ****************************************
  typedef struct packed {
    logic [CFG_N-1:0][7:0] cfg;
    logic upd_seen;
    logic [1:0] restart;
    logic [8:0] stepc;
    logic step;
    logic [LED_N-1:0] led_oe;
    logic [LED_N-1:0] led_o;
  } ldd_sys_t;

  ldd_sys_t s, sn;
  logic upd_s, cap;
  logic [1:0] rate_on;
  logic [LED_N-1:0] led_oe_d;

  // toggle handshake: the link side holds cfg for a whole byte time
  ldd_sync #(.W(1)) u_upd (
    .clk(sys_clk),
    .din(l.upd),
    .dout(upd_s)
  );

  assign cap = upd_s != s.upd_seen;

  always_comb begin
    sn = s;
    sn.restart = 2'h0;
    if (cap) begin
      sn.cfg = l.cfg;
      sn.upd_seen = upd_s;
      // any prescaler write restarts its rate, even with the same value
      sn.restart[0] = l.wsel == 3'(REG_PSC_A - REG_FIRST_RW);
      sn.restart[1] = l.wsel == 3'(REG_PSC_B - REG_FIRST_RW);
    end
    sn.step = 1'b0;
    if (s.stepc == 9'(STEP_CYCLES - 1)) begin
      sn.stepc = 9'h000;
      sn.step = 1'b1;
    end else begin
      sn.stepc = s.stepc + 9'h001;
    end
    sn.led_oe = led_oe_d;
    sn.led_o = '0;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s <= '0;
      s.cfg <= CFG_RST;
    end else begin
      s <= sn;
    end
  end

  // ****************************************
  // system domain: rates and LED drive
  // ****************************************
  for (genvar g = 0; g < 2; g++) begin : g_rate
    ldd_blink #(.W(RATE_W)) u_blink (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .step(s.step),
      .restart(s.restart[g]),
      .prescale(s.cfg[2*g]),
      .duty(s.cfg[2*g+1]),
      .on(rate_on[g])
    );
  end

  for (genvar i = 0; i < LED_N; i++) begin : g_led
    logic [1:0] mode;
    assign mode = s.cfg[CFG_SEL0 + i/4][2*(i%4) +: 2];
    assign led_oe_d[i] = (mode == MODE_ON)
      || (mode == MODE_RATE_A && rate_on[0])
      || (mode == MODE_RATE_B && rate_on[1]);
  end

  assign led_output_n_o = s.led_o;
  assign led_output_n_oe = s.led_oe;

  chk_led_off: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s.cfg[CFG_SEL0][1:0] == MODE_OFF |=> !led_output_n_oe[0])
    else $error("led driven in off state");

  chk_led_on: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s.cfg[CFG_SEL0][3:2] == MODE_ON |=> led_output_n_oe[1])
    else $error("led not driven in on state");

  chk_led_rate: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s.cfg[CFG_SEL0][7:6] == MODE_RATE_B
    |=> led_output_n_oe[3] == $past(rate_on[1]))
    else $error("led does not follow rate b");

  cov_led_blink: cover property (
    @(posedge sys_clk) disable iff (!reset_n)
    s.cfg[CFG_SEL0][5:4] == MODE_RATE_A ##1 $rose(led_output_n_oe[2]));
endmodule
`default_nettype wire

// File: sim/ldd_master.sv
/*
  Behavioural two-wire bus master facing the LED blink driver.
  Assumes a pull-up on the data line and a free running link_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ldd_master (
  // timing
  input wire logic link_clk,
  // bus
  input wire logic sda_oe,
  output logic scl,
  output wire logic sda
);
  logic pull_q = 1'b0;
  logic busy_q = 1'b0;
  initial scl = 1'b1;
  // pull-up: a released line reads high
  assign sda = ~(pull_q | sda_oe);

  // ****************************************
  // bit level
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  // data moves only in the low half of the clock
  task automatic bit_cyc(input logic drv, output logic smp);
    scl <= 1'b0;
    tick(5);
    pull_q <= ~drv;
    tick(5);
    scl <= 1'b1;
    tick(5);
    smp = sda;
    tick(5);
  endtask

  // ****************************************
  // frame level
  // ****************************************
  // a repeated start first brings the clock low to free the line
  task automatic start();
    if (busy_q) begin
      scl <= 1'b0;
      tick(5);
      pull_q <= 1'b0;
      tick(5);
      scl <= 1'b1;
      tick(10);
    end
    pull_q <= 1'b1;
    busy_q <= 1'b1;
    tick(10);
  endtask

  task automatic stop();
    scl <= 1'b0;
    tick(5);
    pull_q <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(10);
    pull_q <= 1'b0;
    busy_q <= 1'b0;
    tick(10);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(b[i], s);
    end
    bit_cyc(1'b1, s);
    ack = ~s;
  endtask

  // the last byte of a read is refused so the slave lets go
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, d[i]);
    end
    bit_cyc(last, s);
  endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
/*
  Self-checking bench for the LED blink driver: register traffic
  over the two-wire bus, LED modes, blink timing and resets.
  Assumes the design runs with STEP_CYCLES set to 4.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top import ldd_pkg::*; ;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] adr = 3'h5;
  logic [15:0] gpio = 16'ha5c3;
  logic [6:0] dev = {DEV_ADDR_HI, 3'h5};
  wire logic scl;
  wire logic sda;
  logic sda_o;
  logic sda_oe;
  logic [15:0] led_o;
  logic [15:0] led_oe;
  // undriven pins read the outside level, driven ones read low
  wire logic [15:0] led_pin = gpio & ~led_oe;
  logic ack;
  int errors = 0;
  int num_checks = 0;

  always #25 sys_clk = ~sys_clk;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  ldd_top #(.STEP_CYCLES(4)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_select_0(adr[0]), .address_select_1(adr[1]),
    .address_select_2(adr[2]), .led_output_n_i(led_pin),
    .led_output_n_o(led_o), .led_output_n_oe(led_oe)
  );
  ldd_master mst_u (.link_clk(link_clk), .sda_oe(sda_oe), .scl(scl),
    .sda(sda));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic logic [7:0] regb(input logic ai, input logic [3:0] a);
    return {3'h0, ai, a};
  endfunction

  task automatic open_w(input logic [7:0] rb);
    mst_u.start();
    mst_u.wbyte({dev, 1'b0}, ack);
    check(32'(ack), 32'h1);
    mst_u.wbyte(rb, ack);
    check(32'(ack), 32'h1);
  endtask

  task automatic wr(input logic [7:0] rb, input logic [7:0] d[$]);
    open_w(rb);
    foreach (d[i]) begin
      mst_u.wbyte(d[i], ack);
      check(32'(ack), 32'h1);
    end
    mst_u.stop();
    repeat (50) @(posedge sys_clk);
  endtask

  // pointer set by a write phase, then a repeated start reads
  task automatic rd(input logic [7:0] rb, input logic [7:0] want[$]);
    logic [7:0] v;
    open_w(rb);
    mst_u.start();
    mst_u.wbyte({dev, 1'b1}, ack);
    check(32'(ack), 32'h1);
    foreach (want[i]) begin
      mst_u.rbyte(i == want.size() - 1, v);
      check(32'(v), 32'(want[i]));
    end
    mst_u.stop();
  endtask

  task automatic on_count(input int idx, input int cyc, input int want);
    int n = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      if (led_oe[idx] === 1'b1) n++;
    end
    check(32'(n), 32'(want));
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (40) @(posedge sys_clk);
    rd(regb(1'b1, REG_PINS_LO), '{8'hc3, 8'ha5, PSC_RST, DUTY_RST, PSC_RST,
      DUTY_RST, SEL_RST, SEL_RST, SEL_RST, SEL_RST, 8'hc3});
    // led0 off, led1 on, led2 rate a, led3 rate b
    wr(regb(1'b1, REG_PSC_A), '{8'h00, 8'h40, 8'h01, 8'h80, 8'he4});
    check(32'(led_oe[1:0]), 32'h2);
    check(32'({sda_o, led_o}), 32'h0);
    on_count(2, 1024, 256);
    on_count(3, 2048, 1024);
    rd(regb(1'b0, REG_PINS_LO), '{8'hc1});
    wr(regb(1'b1, 4'h8), '{8'h00, 8'h55, 8'h07});
    rd(regb(1'b1, 4'h8), '{8'h00, 8'h55, 8'hc1, 8'h05, 8'h07});
    wr(regb(1'b0, REG_DUTY_B), '{8'h00, 8'h22, 8'h33});
    rd(regb(1'b1, REG_DUTY_B), '{8'h33, 8'he4});
    wr(regb(1'b0, REG_PINS_LO), '{8'hff});
    rd(regb(1'b0, REG_PINS_LO), '{8'hc1});
    mst_u.start();
    mst_u.wbyte({DEV_ADDR_HI, 3'h2, 1'b0}, ack);
    check(32'(ack), 32'h0);
    mst_u.stop();
    @(posedge sys_clk);
    adr <= 3'h2;
    dev = {DEV_ADDR_HI, 3'h2};
    repeat (20) @(posedge sys_clk);
    rd(regb(1'b0, REG_PSC_A), '{8'h07});
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    check(32'(led_oe), 32'h0);
    reset_n <= 1'b1;
    repeat (40) @(posedge sys_clk);
    rd(regb(1'b1, REG_PSC_A), '{PSC_RST, DUTY_RST, PSC_RST, DUTY_RST,
      SEL_RST});
    wrap_up();
  end

  // the whole sequence needs about 2.2 ms
  initial begin
    #5_000_000;
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
